//--- rtl/alf_auto_line_feed.sv
`timescale 1ns/10ps
// What this block does
// - With transmit switch on, a keyboard CR is followed by an LF to UART.
// - With the jumper fitted, each received UART character is checked; a CR gets an LF after it.
// - Receive insertion happens only with the jumper fitted.
// - Jumper never affects transmit insertion; only the switch does.
// - Received LF is driven on the shared buffer data path after the CR.
// - Inserted codes look exactly like ordinary characters or keystrokes.
// - Local mode with both on: one CR gives two LFs at printer.
// - Echo mode: one LF sent; echoed CR adds a receive LF.
// - Transmit switch off: keyboard data and strobe pass straight through.
// - After UART takes CR, block keyboard and send LF with a one-cycle strobe until taken.
// - Received CR with avail, once consumed: gate UART off, drive LF, flag avail.
module alf_auto_line_feed #(
    parameter int W = alf_pkg::CHAR_W
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         nrst_i,
    // Option controls
    input  wire logic         transmit_autofeed_switch_i,
    input  wire logic         receive_insert_jumper_i,
    // Keyboard side
    input  wire logic [W-1:0] kbd_data_i,
    input  wire logic         kbd_strobe_i,
    // UART transmitter side
    input  wire logic         uart_tx_accept_n_i,
    output logic [W-1:0]      tx_data_o,
    output logic              generated_keystrobe_o,
    // UART receiver and character buffer side
    input  wire logic         uart_char_avail_n_i,
    input  wire logic         char_consumed_clear_n_i,
    input  wire logic [W-1:0] rx_data_i,
    output logic              uart_output_gate_o,
    output logic              inserted_char_avail_n_o,
    output logic [W-1:0]      rx_data_o,
    output logic              rx_data_oe_o
);

    // ****************************************
    // Transmit insertion
    // ****************************************
    alf_pkg::alf_tx_state_e state;
    alf_pkg::alf_tx_state_e next_state;
    logic                   acc_d;
    logic                   next_acc_d;
    logic                   acc_fall;
    logic                   cr_key;
    logic                   lf_strobe;
    logic                   next_lf_strobe;

    assign next_acc_d = uart_tx_accept_n_i;
    assign acc_fall   = acc_d & ~uart_tx_accept_n_i;
    // Switch alone qualifies the transmit CR
    assign cr_key = transmit_autofeed_switch_i && kbd_strobe_i
                    && kbd_data_i == alf_pkg::CODE_CR[W-1:0];

    always_comb begin
        next_state     = state;
        next_lf_strobe = 1'b0;
        case (state)
            alf_pkg::ALF_TX_IDLE: begin
                if (cr_key) begin
                    next_state = alf_pkg::ALF_TX_CR_SENT;
                end
            end
            alf_pkg::ALF_TX_CR_SENT: begin
                if (acc_fall) begin
                    next_state     = alf_pkg::ALF_TX_LF_OUT;
                    next_lf_strobe = 1'b1;
                end
            end
            alf_pkg::ALF_TX_LF_OUT: begin
                if (acc_fall && !lf_strobe) begin
                    next_state = alf_pkg::ALF_TX_IDLE;
                end
            end
            default: next_state = alf_pkg::ALF_TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state     <= alf_pkg::ALF_TX_IDLE;
            acc_d     <= 1'b1;
            lf_strobe <= alf_pkg::RST_TX_BUSY;
        end else begin
            state     <= next_state;
            acc_d     <= next_acc_d;
            lf_strobe <= next_lf_strobe;
        end
    end

    // Keyboard blocked only while LF is out; else pass through
    assign tx_data_o = (state == alf_pkg::ALF_TX_LF_OUT)
                       ? alf_pkg::CODE_LF[W-1:0]
                       : kbd_data_i;
    assign generated_keystrobe_o = (state == alf_pkg::ALF_TX_LF_OUT)
                                   ? lf_strobe
                                   : kbd_strobe_i;

    // ****************************************
    // Receive insertion
    // ****************************************
    alf_rx_insert #(
        .W(W)
    ) u_rx (
        .sys_clk_i              (sys_clk_i),
        .nrst_i                 (nrst_i),
        .receive_insert_jumper_i(receive_insert_jumper_i),
        .uart_char_avail_n_i    (uart_char_avail_n_i),
        .char_consumed_clear_n_i(char_consumed_clear_n_i),
        .rx_data_i              (rx_data_i),
        .uart_output_gate_o     (uart_output_gate_o),
        .inserted_char_avail_n_o(inserted_char_avail_n_o),
        .rx_data_o              (rx_data_o),
        .rx_data_oe_o           (rx_data_oe_o)
    );

    // ****************************************
    // Assertions
    // ****************************************
    tx_cr_catch_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_TX_IDLE && cr_key)
        |=> state == alf_pkg::ALF_TX_CR_SENT)
        else $error("keyboard CR not caught");
    tx_switch_only_a: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (state == alf_pkg::ALF_TX_IDLE && !transmit_autofeed_switch_i)
        |=> state == alf_pkg::ALF_TX_IDLE)
        else $error("transmit insert without switch");
    tx_pass_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state != alf_pkg::ALF_TX_LF_OUT |-> tx_data_o == kbd_data_i
        && generated_keystrobe_o == kbd_strobe_i)
        else $error("keyboard not passed through");
    tx_lf_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_TX_CR_SENT && acc_fall)
        |=> generated_keystrobe_o && tx_data_o == 8'h0A
        ##1 !generated_keystrobe_o)
        else $error("LF strobe not one cycle");
    tx_release_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_TX_LF_OUT && acc_fall && !lf_strobe)
        |=> state == alf_pkg::ALF_TX_IDLE)
        else $error("keyboard not released");
    tx_insert_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state == alf_pkg::ALF_TX_LF_OUT ##1 state == alf_pkg::ALF_TX_IDLE);
    both_insert_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state == alf_pkg::ALF_TX_LF_OUT && !inserted_char_avail_n_o);

endmodule : alf_auto_line_feed

//--- rtl/alf_pkg.sv
package alf_pkg;

    // Character codes and width
    localparam logic [7:0] CODE_CR       = 8'h0D;
    localparam logic [7:0] CODE_LF       = 8'h0A;
    localparam int         CHAR_W        = 8;

    // Reset values
    localparam logic       RST_TX_BUSY   = 1'b0;
    localparam logic       RST_RX_GATE   = 1'b1;

    typedef enum logic [1:0] {
        ALF_TX_IDLE,
        ALF_TX_CR_SENT,
        ALF_TX_LF_OUT
    } alf_tx_state_e;

    typedef enum logic [1:0] {
        ALF_RX_IDLE,
        ALF_RX_CR_HELD,
        ALF_RX_LF_OUT
    } alf_rx_state_e;

endpackage : alf_pkg

//--- rtl/alf_rx_insert.sv
`timescale 1ns/10ps
module alf_rx_insert #(
    parameter int W = alf_pkg::CHAR_W
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         nrst_i,
    // Receive stream
    input  wire logic         receive_insert_jumper_i,
    input  wire logic         uart_char_avail_n_i,
    input  wire logic         char_consumed_clear_n_i,
    input  wire logic [W-1:0] rx_data_i,
    // Insertion outputs
    output logic              uart_output_gate_o,
    output logic              inserted_char_avail_n_o,
    output logic [W-1:0]      rx_data_o,
    output logic              rx_data_oe_o
);

    alf_pkg::alf_rx_state_e state;
    alf_pkg::alf_rx_state_e next_state;
    logic                   clr_d;
    logic                   next_clr_d;
    logic                   clr_rise;

    assign next_clr_d = char_consumed_clear_n_i;
    assign clr_rise   = char_consumed_clear_n_i & ~clr_d;

    always_comb begin
        next_state = state;
        case (state)
            alf_pkg::ALF_RX_IDLE: begin
                if (receive_insert_jumper_i && !uart_char_avail_n_i
                    && rx_data_i == alf_pkg::CODE_CR[W-1:0]) begin
                    next_state = alf_pkg::ALF_RX_CR_HELD;
                end
            end
            alf_pkg::ALF_RX_CR_HELD: begin
                if (clr_rise) begin
                    next_state = alf_pkg::ALF_RX_LF_OUT;
                end
            end
            alf_pkg::ALF_RX_LF_OUT: begin
                if (clr_rise) begin
                    next_state = alf_pkg::ALF_RX_IDLE;
                end
            end
            default: next_state = alf_pkg::ALF_RX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state <= alf_pkg::ALF_RX_IDLE;
            clr_d <= 1'b1;
        end else begin
            state <= next_state;
            clr_d <= next_clr_d;
        end
    end

    // Gate drops once CR consumed; LF driven as ordinary char
    assign uart_output_gate_o = (state != alf_pkg::ALF_RX_LF_OUT);
    assign rx_data_oe_o       = (state == alf_pkg::ALF_RX_LF_OUT);
    assign inserted_char_avail_n_o =
        (state != alf_pkg::ALF_RX_LF_OUT);
    assign rx_data_o = alf_pkg::CODE_LF[W-1:0];

    // ****************************************
    // Assertions
    // ****************************************
    rx_cr_detect_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_RX_IDLE && receive_insert_jumper_i
         && !uart_char_avail_n_i && rx_data_i == alf_pkg::CODE_CR[W-1:0])
        |=> state == alf_pkg::ALF_RX_CR_HELD)
        else $error("received CR not caught");
    rx_jumper_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_RX_IDLE && !receive_insert_jumper_i)
        |=> state == alf_pkg::ALF_RX_IDLE)
        else $error("insertion without jumper");
    rx_lf_drive_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !inserted_char_avail_n_o |-> rx_data_oe_o && !uart_output_gate_o
        && rx_data_o == 8'h0A)
        else $error("LF not driven with avail");
    rx_lf_start_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_RX_CR_HELD && clr_rise)
        |=> !inserted_char_avail_n_o)
        else $error("LF not started after clear");
    rx_lf_end_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (state == alf_pkg::ALF_RX_LF_OUT && clr_rise)
        |=> uart_output_gate_o && inserted_char_avail_n_o)
        else $error("UART not restored");
    rx_insert_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state == alf_pkg::ALF_RX_LF_OUT ##1 state == alf_pkg::ALF_RX_IDLE);

endmodule : alf_rx_insert

//--- dv/alf_far_model.sv
`timescale 1ns/10ps
// ****
// UART pair and character buffer
// ****
module alf_far_model #(
    parameter int DLY = 3
) (
    // Clock and mode
    input  wire logic       sys_clk_i,
    input  wire logic       loop_i,
    // Transmit side
    input  wire logic [7:0] tx_data_i,
    input  wire logic       keystrobe_i,
    output logic            accept_n_o = 1'b0,
    // Receive side
    input  wire logic       gate_i,
    input  wire logic       ins_avail_n_i,
    input  wire logic [7:0] ins_data_i,
    input  wire logic       ins_oe_i,
    output logic            avail_n_o  = 1'b1,
    output logic            clear_n_o  = 1'b1,
    output logic [7:0]      data_o     = 8'h00
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic [7:0] bufq[$];
    int         cnt = 0;
    int         gap = 0;
    logic       avail;

    assign avail = (gate_i && !avail_n_o) || !ins_avail_n_i;

    always @(posedge sys_clk_i) begin
        if (keystrobe_i && !accept_n_o) begin
            txq.push_back(tx_data_i);
            if (loop_i)
                rxq.push_back(tx_data_i);
            accept_n_o <= 1'b1;
            cnt <= DLY;
        end else if (cnt > 1)
            cnt <= cnt - 1;
        else
            accept_n_o <= 1'b0;
        clear_n_o <= 1'b1;
        if (gap > 0)
            gap <= gap - 1;
        else if (avail) begin
            bufq.push_back(ins_oe_i ? ins_data_i : data_o);
            if (!avail_n_o && gate_i)
                avail_n_o <= 1'b1;
            clear_n_o <= 1'b0;
            gap <= 4;
        end
        // Released output toggles every cycle
        if (avail_n_o && clear_n_o && rxq.size() > 0) begin
            data_o <= rxq.pop_front();
            avail_n_o <= 1'b0;
        end else if (avail_n_o)
            data_o <= ~data_o;
    end
endmodule : alf_far_model

//--- dv/test_alf_auto_line_feed.sv
`timescale 1ns/10ps
// ****
// Bench
// ****
module test_alf_auto_line_feed;
    logic       sys_clk = 1'b0;
    logic       nrst    = 1'b0;
    logic       sw      = 1'b0;
    logic       jmp     = 1'b0;
    logic       loop    = 1'b0;
    logic       kstb    = 1'b0;
    logic [7:0] kdata   = 8'h00;
    logic [7:0] tx_data, rxd, ud;
    logic       kstb_o, gate, ins_n, oe, acc_n, av_n, clr_n;
    int         n_mismatch = 0;
    int         n_tests    = 0;
    int         cyc        = 0;

    alf_auto_line_feed dut (
        .sys_clk_i(sys_clk), .nrst_i(nrst),
        .transmit_autofeed_switch_i(sw), .receive_insert_jumper_i(jmp),
        .kbd_data_i(kdata), .kbd_strobe_i(kstb),
        .uart_tx_accept_n_i(acc_n), .tx_data_o(tx_data),
        .generated_keystrobe_o(kstb_o), .uart_char_avail_n_i(av_n),
        .char_consumed_clear_n_i(clr_n), .rx_data_i(ud),
        .uart_output_gate_o(gate), .inserted_char_avail_n_o(ins_n),
        .rx_data_o(rxd), .rx_data_oe_o(oe)
    );
    alf_far_model far (
        .sys_clk_i(sys_clk), .loop_i(loop), .tx_data_i(tx_data),
        .keystrobe_i(kstb_o), .accept_n_o(acc_n), .gate_i(gate),
        .ins_avail_n_i(ins_n), .ins_data_i(rxd), .ins_oe_i(oe),
        .avail_n_o(av_n), .clear_n_o(clr_n), .data_o(ud)
    );

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic chkq(ref logic [7:0] q[$], input logic [7:0] e[$]);
        chk(8'(q.size()), 8'(e.size()));
        foreach (e[i])
            if (i < q.size())
                chk(q[i], e[i]);
        q.delete();
    endtask : chkq

    // Wait until both paths stay idle
    task automatic settle();
        int k;
        int q;
        k = 0;
        q = 0;
        while (q < 12 && k < 400) begin
            @(posedge sys_clk);
            k++;
            q = (acc_n === 1'b0 && gate === 1'b1 && ins_n === 1'b1 &&
                 av_n === 1'b1 && far.rxq.size() == 0 && far.gap == 0)
                ? q + 1 : 0;
        end
        if (k == 400)
            chk(8'h01, 8'h00);
        // Step off the edge so callers change inputs between edges
        #1;
    endtask : settle

    task automatic press(input logic [7:0] c);
        @(posedge sys_clk);
        #1 kdata = c;
        kstb = 1'b1;
        @(posedge sys_clk);
        #1 kstb = 1'b0;
        settle();
    endtask : press

    task automatic t_reset();
        kdata = 8'h41;
        #1 chk(gate, 1'b1);
        chk(ins_n, 1'b1);
        chk(oe, 1'b0);
        chk(tx_data, 8'h41);
        $display("test reset done");
    endtask : t_reset

    task automatic t_pass();
        jmp = 1'b1;
        @(posedge sys_clk);
        #1 kdata = 8'h0D;
        kstb = 1'b1;
        #1 chk(tx_data, 8'h0D);
        chk(kstb_o, 1'b1);
        @(posedge sys_clk);
        #1 kstb = 1'b0;
        settle();
        chkq(far.txq, '{8'h0D});
        $display("test passthrough done");
    endtask : t_pass

    task automatic t_tx();
        sw = 1'b1;
        jmp = 1'b0;
        press(8'h0D);
        press(8'h41);
        chkq(far.txq, '{8'h0D, 8'h0A, 8'h41});
        $display("test transmit done");
    endtask : t_tx

    task automatic t_rx();
        sw = 1'b0;
        jmp = 1'b1;
        #1 far.rxq = '{8'h0D, 8'h0D, 8'h42};
        settle();
        chkq(far.bufq, '{8'h0D, 8'h0A, 8'h0D, 8'h0A, 8'h42});
        jmp = 1'b0;
        #1 far.rxq = '{8'h0D, 8'h43};
        settle();
        chkq(far.bufq, '{8'h0D, 8'h43});
        $display("test receive done");
    endtask : t_rx

    task automatic t_loop();
        sw = 1'b1;
        jmp = 1'b1;
        loop = 1'b1;
        press(8'h0D);
        chkq(far.txq, '{8'h0D, 8'h0A});
        chkq(far.bufq, '{8'h0D, 8'h0A, 8'h0A});
        $display("test echo done");
    endtask : t_loop

    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial begin
        repeat (5) @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_reset();
        t_pass();
        t_tx();
        t_rx();
        t_loop();
        results();
    end
endmodule : test_alf_auto_line_feed
